// *** src/pllcg_consts.svh ***
`ifndef PLLCG_CONSTS_SVH
`define PLLCG_CONSTS_SVH

// Register indices; the byte address is four times the index
`define PLLCG_IDX_PLL_STATUS 16'h7011
`define PLLCG_IDX_HS_PRESCALE 16'h701a
`define PLLCG_IDX_LS_PRESCALE 16'h701b
`define PLLCG_IDX_PCLK_EN0 16'h701c
`define PLLCG_IDX_PCLK_EN1 16'h701d
`define PLLCG_IDX_LPM_CTRL 16'h701e
`define PLLCG_IDX_PCLK_EN3 16'h7020
`define PLLCG_IDX_PLL_RATIO 16'h7021
`define PLLCG_IDX_SYS_CTRL 16'h7022
`define PLLCG_IDX_WD_COUNT 16'h7023
`define PLLCG_IDX_WD_KEY 16'h7025
`define PLLCG_IDX_WD_CTRL 16'h7029
`define PLLCG_IDX_PWM_REMAP 16'h702e

// Field positions
`define PLLCG_STS_LOCK_BIT 0
`define PLLCG_STS_RATIO_SELECT_LSB 1
`define PLLCG_STS_RATIO_SELECT_MSB 2
`define PLLCG_MULT_MSB 3
`define PLLCG_LPM_MSB 1

// Reset values
`define PLLCG_RST_WORD 16'h0000
`define PLLCG_RST_MULT 4'h0
`define PLLCG_RST_RATIO_SELECT 2'h0

// Encodings and limits
`define PLLCG_MULT_BYPASS 4'h0
`define PLLCG_MULT_MAX 4'ha
`define PLLCG_RATIO_SELECT_QUARTER_HI 2'h1
`define PLLCG_RATIO_SELECT_HALF 2'h2
`define PLLCG_RATIO_SELECT_ONE 2'h3
`define PLLCG_DIV_QUARTER 3'h4
`define PLLCG_DIV_HALF 3'h2
`define PLLCG_DIV_ONE 3'h1

// Timing counts
`define PLLCG_LOCK_CYCLES 131072
`define PLLCG_EN_DELAY 2'h2

`endif

// *** src/pllcg_pkg.sv ***
package pllcg_pkg;

  // Lock tracking of the multiplier loop
  typedef enum logic [1:0] {
    PLLCG_LOCKED,
    PLLCG_LOCKING
  } pllcg_lock_e;

  typedef logic [15:0] pllcg_word_t;

endpackage

// *** src/pllcg_tick_if.sv ***
`timescale 1ns/100ps
interface pllcg_tick_if;
  logic [3:0] mult;
  logic [2:0] div;
  logic tick;

  // Control side sets the rate, generator side returns ticks
  modport ctrl (output mult, output div, input tick);
  modport gen (input mult, input div, output tick);
endinterface

// *** src/pllcg_rate_ticker.sv ***
`timescale 1ns/100ps
`include "pllcg_consts.svh"
module pllcg_rate_ticker
  import pllcg_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Rate in, ticks out
  pllcg_tick_if.gen tk
);

  logic [4:0] acc_q;
  logic [4:0] acc_d;
  logic [4:0] sum;
  logic [4:0] div_w;
  logic tick_q;
  logic tick_d;

  // Fractional rate: mult/div ticks per oscillator cycle, at most one
  always_comb begin
    div_w = {2'h0, tk.div};
    sum = acc_q + {1'h0, tk.mult};
    tick_d = 1'b0;
    acc_d = sum;
    if (sum >= div_w) begin
      tick_d = 1'b1;
      acc_d = sum - div_w;
    end
    // Saturate so a rate above one tick a cycle cannot wind up
    if (acc_d >= div_w) begin
      acc_d = div_w - 5'h01;
    end
  end

  // Accumulator and registered tick
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      acc_q <= 5'h00;
      tick_q <= 1'b0;
    end else begin
      acc_q <= acc_d;
      tick_q <= tick_d;
    end
  end

  assign tk.tick = tick_q;

endmodule

// *** src/pllcg_clock_gen.sv ***
`timescale 1ns/100ps
`include "pllcg_consts.svh"
module pllcg_clock_gen
  import pllcg_pkg::*;
#(
  parameter int ADDR_W = 18,
  parameter int LOCK_CYC = `PLLCG_LOCK_CYCLES
) (
  // Oscillator clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Register port
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  // Clock outputs
  output logic system_clock_out_o,
  output logic [3:0] pll_mult_o,
  output logic pll_bypass_o,
  output logic pll_lock_done_o,
  // Peripheral clock gates and settings
  output logic [15:0] periph_clock_enables0_o,
  output logic [15:0] periph_clock_enables1_o,
  output logic [15:0] periph_clock_enables3_o,
  output logic [15:0] hs_prescale_o,
  output logic [15:0] ls_prescale_o,
  output logic [1:0] lpm_mode_o
);

  // The multiplier loop itself is not built: the system clock leaves as a
  // one-cycle tick stream on the oscillator clock, at most one tick a cycle.
  // Bypass forces a multiplier of one, so the divided oscillator rate shows.
  // A rate above the oscillator rate is capped, a known model limitation.
  // Registers are word indices on a byte address four times the index.
  // Read data stand one cycle after the strobe and read zero otherwise.
  localparam int CW = $clog2(LOCK_CYC + 1);
  localparam logic [CW-1:0] LOCK_LOAD = CW'(LOCK_CYC - 1);
  localparam logic [1:0] EN_NONE = 2'h3;
  localparam logic [2:0] MISC_NONE = 3'h7;

  // Word index of a byte address; misaligned addresses decode nowhere
  function automatic logic [15:0] word_idx(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] sh;
    sh = a >> 2;
    if (a[1:0] != 2'h0) begin
      word_idx = 16'hffff;
    end else begin
      word_idx = sh[15:0];
    end
  endfunction

  // Slot of a peripheral clock enable register
  function automatic logic [1:0] en_slot(input logic [15:0] idx);
    case (idx)
      `PLLCG_IDX_PCLK_EN0: en_slot = 2'h0;
      `PLLCG_IDX_PCLK_EN1: en_slot = 2'h1;
      `PLLCG_IDX_PCLK_EN3: en_slot = 2'h2;
      default: en_slot = EN_NONE;
    endcase
  endfunction

  // Slot of a plain storage register
  function automatic logic [2:0] misc_slot(input logic [15:0] idx);
    case (idx)
      `PLLCG_IDX_HS_PRESCALE: misc_slot = 3'h0;
      `PLLCG_IDX_LS_PRESCALE: misc_slot = 3'h1;
      `PLLCG_IDX_LPM_CTRL: misc_slot = 3'h2;
      `PLLCG_IDX_SYS_CTRL: misc_slot = 3'h3;
      `PLLCG_IDX_WD_KEY: misc_slot = 3'h4;
      `PLLCG_IDX_WD_CTRL: misc_slot = 3'h5;
      `PLLCG_IDX_PWM_REMAP: misc_slot = 3'h6;
      default: misc_slot = MISC_NONE;
    endcase
  endfunction

  pllcg_tick_if tk ();

  // Decoded register selects
  logic [15:0] idx;
  logic [1:0] wr_en_slot;
  logic [2:0] wr_misc_slot;
  logic sts_hit;
  logic ratio_hit;

  // Multiplier loop state
  logic [3:0] mult_q;
  logic [1:0] ratio_select_q;
  pllcg_lock_e lock_state_q;
  logic [CW-1:0] lock_cnt_q;
  logic lock_done_q;
  logic lock_fire;
  logic mult_wr;
  logic bypass;

  // Peripheral clock enable staging, one slot per register
  logic [15:0] en_q [3];
  logic [15:0] en_pend_val_q [3];
  logic en_pend_q [3];
  logic [1:0] en_cnt_q [3];
  logic en_apply [3];

  // Plain storage and read path
  logic [15:0] misc_q [7];
  logic [15:0] rdata_q;
  logic [15:0] rd_val;

  // Address decode shared by reads and writes
  always_comb begin
    idx = word_idx(addr_i);
    wr_en_slot = en_slot(idx);
    wr_misc_slot = misc_slot(idx);
    sts_hit = (idx == `PLLCG_IDX_PLL_STATUS);
    ratio_hit = (idx == `PLLCG_IDX_PLL_RATIO);
  end

  // Reserved multiplier codes are dropped so the loop never sees them
  assign mult_wr = wr_i && ratio_hit &&
                   (wdata_i[`PLLCG_MULT_MSB:0] <= `PLLCG_MULT_MAX);

  // Multiplier field of the ratio register
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mult_q <= `PLLCG_RST_MULT;
    end else if (mult_wr) begin
      mult_q <= wdata_i[`PLLCG_MULT_MSB:0];
    end
  end

  // Ratio select field of the status register; lock bit is read only
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ratio_select_q <= `PLLCG_RST_RATIO_SELECT;
    end else if (wr_i && sts_hit) begin
      ratio_select_q <= wdata_i[`PLLCG_STS_RATIO_SELECT_MSB:`PLLCG_STS_RATIO_SELECT_LSB];
    end
  end

  // Lock timer restarts on every accepted multiplier write
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      lock_state_q <= PLLCG_LOCKED;
      lock_cnt_q <= '0;
    end else if (mult_wr) begin
      lock_state_q <= PLLCG_LOCKING;
      lock_cnt_q <= LOCK_LOAD;
    end else begin
      case (lock_state_q)
        PLLCG_LOCKING: begin
          // Count down to zero, then one more edge declares lock
          if (lock_cnt_q == '0) begin
            lock_state_q <= PLLCG_LOCKED;
          end else begin
            lock_cnt_q <= lock_cnt_q - 1'b1;
          end
        end
        PLLCG_LOCKED: begin
          lock_cnt_q <= '0;
        end
        default: begin
          lock_state_q <= PLLCG_LOCKED;
        end
      endcase
    end
  end

  // Count has run out while still settling
  assign lock_fire = (lock_state_q == PLLCG_LOCKING) && (lock_cnt_q == '0);

  // Lock flag; a write beats a finishing count since that count is stale
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      lock_done_q <= 1'b1;
    end else if (mult_wr) begin
      lock_done_q <= 1'b0;
    end else if (lock_fire) begin
      lock_done_q <= 1'b1;
    end
  end

  // Bypass while the multiplier is zero or the loop is still settling
  assign bypass = (mult_q == `PLLCG_MULT_BYPASS) ||
                  (lock_state_q != PLLCG_LOCKED);

  // Rate fed to the tick generator
  always_comb begin
    // Bypass runs the ticker at a multiplier of one, still divided by the ratio select
    tk.mult = bypass ? 4'h1 : mult_q;
    case (ratio_select_q)
      `PLLCG_RATIO_SELECT_HALF: tk.div = `PLLCG_DIV_HALF;
      // Undivided only when bypassed; with the loop running it falls to /2
      `PLLCG_RATIO_SELECT_ONE: tk.div = bypass ? `PLLCG_DIV_ONE : `PLLCG_DIV_HALF;
      default: tk.div = `PLLCG_DIV_QUARTER;
    endcase
  end

  pllcg_rate_ticker u_ticker (
    .clk_i (clk_i),
    .rstn_i (rstn_i),
    .tk (tk)
  );

  // CPU clock tick leaves unchanged as system clock out
  assign system_clock_out_o = tk.tick;

  // A staged write is due on the second tick after it was taken
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      en_apply[i] = en_pend_q[i] && tk.tick &&
                    (en_cnt_q[i] == (`PLLCG_EN_DELAY - 2'h1));
    end
  end

  // Peripheral clock enables: stage the write, apply on the second tick
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int i = 0; i < 3; i++) begin
        en_q[i] <= `PLLCG_RST_WORD;
        en_pend_val_q[i] <= `PLLCG_RST_WORD;
        en_pend_q[i] <= 1'b0;
        en_cnt_q[i] <= 2'h0;
      end
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (wr_i && (wr_en_slot == 2'(i))) begin
          en_pend_val_q[i] <= wdata_i;
          en_pend_q[i] <= 1'b1;
          en_cnt_q[i] <= 2'h0;
        end else if (en_apply[i]) begin
          en_q[i] <= en_pend_val_q[i];
          en_pend_q[i] <= 1'b0;
          en_cnt_q[i] <= 2'h0;
        end else if (en_pend_q[i] && tk.tick) begin
          en_cnt_q[i] <= en_cnt_q[i] + 2'h1;
        end
      end
    end
  end

  // Plain storage registers
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int i = 0; i < 7; i++) begin
        misc_q[i] <= `PLLCG_RST_WORD;
      end
    end else if (wr_i && (wr_misc_slot != MISC_NONE)) begin
      misc_q[wr_misc_slot] <= wdata_i;
    end
  end

  // Read mux; enable registers read back what software last wrote
  // Watchdog counter and unmapped indices fall through to zero
  always_comb begin
    rd_val = 16'h0000;
    if (wr_en_slot != EN_NONE) begin
      rd_val = en_pend_val_q[wr_en_slot];
    end else if (wr_misc_slot != MISC_NONE) begin
      rd_val = misc_q[wr_misc_slot];
    end else if (sts_hit) begin
      rd_val[`PLLCG_STS_LOCK_BIT] = lock_done_q;
      rd_val[`PLLCG_STS_RATIO_SELECT_MSB:`PLLCG_STS_RATIO_SELECT_LSB] = ratio_select_q;
    end else if (ratio_hit) begin
      rd_val[`PLLCG_MULT_MSB:0] = mult_q;
    end
  end

  // Read data stands only in the cycle after the strobe
  // Clearing between reads keeps stale data off the bus
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_q <= 16'h0000;
    end else if (rd_i) begin
      rdata_q <= rd_val;
    end else begin
      rdata_q <= 16'h0000;
    end
  end

  // Outputs
  assign rdata_o = rdata_q;
  assign pll_mult_o = mult_q;
  assign pll_bypass_o = bypass;
  assign pll_lock_done_o = lock_done_q;
  assign periph_clock_enables0_o = en_q[0];
  assign periph_clock_enables1_o = en_q[1];
  assign periph_clock_enables3_o = en_q[2];
  assign hs_prescale_o = misc_q[0];
  assign ls_prescale_o = misc_q[1];
  assign lpm_mode_o = misc_q[2][`PLLCG_LPM_MSB:0];

endmodule

// *** tb/pllcg_clock_gen_sva.sv ***
`timescale 1ns/100ps
`include "pllcg_consts.svh"
module pllcg_checker #(
  parameter int ADDR_W = 18,
  parameter int LOCK_CYC = `PLLCG_LOCK_CYCLES
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Register port
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [15:0] rdata_o,
  // Clock outputs
  input wire logic system_clock_out_o,
  input wire logic [3:0] pll_mult_o,
  input wire logic pll_bypass_o,
  input wire logic pll_lock_done_o,
  input wire logic [15:0] periph_clock_enables0_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  logic ratio_wr;
  logic en_wr;
  int unsigned since_q;
  // Reserved multiplier codes must not count as ratio writes
  assign ratio_wr = wr_i && addr_i == {`PLLCG_IDX_PLL_RATIO, 2'h0}
                    && wdata_i[3:0] <= `PLLCG_MULT_MAX;
  assign en_wr = wr_i && addr_i == {`PLLCG_IDX_PCLK_EN0, 2'h0};
  // Cycles since the last ratio write, saturating once lock is due
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      since_q <= 0;
    end else if (ratio_wr) begin
      since_q <= 1;
    end else if (since_q != 0 && since_q <= LOCK_CYC) begin
      since_q <= since_q + 1;
    end
  end
  sequence en_write_s;
    en_wr;
  endsequence
  sequence en_hold_s;
    $stable(periph_clock_enables0_o) [*2];
  endsequence
  rd_idle_a: assert property (!rd_i |=> rdata_o == 16'h0)
    else $error("read data not zero outside a read");
  rd_misalign_a: assert property (rd_i && addr_i[1:0] != 2'h0
    |=> rdata_o == 16'h0) else $error("misaligned read not zero");
  wd_count_a: assert property (rd_i && addr_i == {`PLLCG_IDX_WD_COUNT,
    2'h0} |=> rdata_o == 16'h0) else $error("counter read not zero");
  lock_read_a: assert property (
    rd_i && addr_i == {`PLLCG_IDX_PLL_STATUS, 2'h0}
    |=> rdata_o[0] == $past(pll_lock_done_o)) else $error("lock bit read");
  mult_load_a: assert property (
    ratio_wr |=> pll_mult_o == $past(wdata_i[3:0])) else $error("mult load");
  reserved_drop_a: assert property (
    wr_i && addr_i == {`PLLCG_IDX_PLL_RATIO, 2'h0}
    && wdata_i[3:0] > `PLLCG_MULT_MAX |=> $stable(pll_mult_o))
    else $error("reserved multiplier taken");
  lock_time_a: assert property (
    pll_lock_done_o == (since_q == 0 || since_q > LOCK_CYC))
    else $error("lock flag timing wrong");
  bypass_mode_a: assert property (
    pll_bypass_o == (pll_mult_o == 4'h0 || !pll_lock_done_o))
    else $error("bypass mode wrong");
  en_hold_a: assert property (en_write_s |=> en_hold_s)
    else $error("enable applied too early");
  en_on_tick_a: assert property (
    $changed(periph_clock_enables0_o) |-> $past(system_clock_out_o))
    else $error("enable changed without a tick");
endmodule

bind pllcg_clock_gen pllcg_checker #(.ADDR_W(ADDR_W), .LOCK_CYC(LOCK_CYC))
  u_chk (.clk_i, .rstn_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
  .system_clock_out_o, .pll_mult_o, .pll_bypass_o, .pll_lock_done_o,
  .periph_clock_enables0_o);

// *** tb/tb_pll_clock_generation.sv ***
`timescale 1ns/100ps
`include "pllcg_consts.svh"
module tb_pll_clock_generation
  import pllcg_pkg::*;
;
  localparam int LCYC = 16;
  localparam logic [15:0] STS = `PLLCG_IDX_PLL_STATUS;
  localparam logic [15:0] RAT = `PLLCG_IDX_PLL_RATIO;
  logic clk_i = 0;
  logic rstn_i = 0;
  logic wr_i = 0;
  logic rd_i = 0;
  logic rd_d = 0;
  logic [17:0] addr_i = '0;
  pllcg_word_t wdata_i = '0;
  pllcg_word_t rdata_o, en0, en1, en3, hs, ls, dv;
  logic tick, byp, lock;
  logic [3:0] mult;
  logic [1:0] lpm;
  pllcg_word_t q[$];
  pllcg_word_t sv[7];
  pllcg_word_t regs[7] = '{16'h701a, 16'h701b, 16'h701e, 16'h7022,
                           16'h7025, 16'h7029, 16'h702e};
  int bad_count = 0;
  int n_checks = 0;
  int mm, dd, e;
  always #2.5 clk_i = ~clk_i;
  pllcg_clock_gen #(.LOCK_CYC(LCYC)) dut (.clk_i, .rstn_i, .addr_i,
    .wdata_i, .wr_i, .rd_i, .rdata_o, .system_clock_out_o(tick),
    .pll_mult_o(mult), .pll_bypass_o(byp), .pll_lock_done_o(lock),
    .periph_clock_enables0_o(en0), .periph_clock_enables1_o(en1),
    .periph_clock_enables3_o(en3), .hs_prescale_o(hs), .ls_prescale_o(ls),
    .lpm_mode_o(lpm));
  task chk(input pllcg_word_t s, input pllcg_word_t x);
    n_checks++;
    if (s !== x) begin
      bad_count++;
      $display("[FAIL] %0t: got %h want %h", $time, s, x);
    end
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Bus master: one-cycle strobes, read expectation queued for the monitor
  task wr(input pllcg_word_t i, input pllcg_word_t d);
    @(posedge clk_i);
    addr_i <= {i, 2'h0};
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task rd(input logic [17:0] a, input pllcg_word_t x);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    q.push_back(x);
    @(posedge clk_i);
    rd_i <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe: look mid-cycle
  always @(posedge clk_i) rd_d <= rd_i;
  always @(negedge clk_i) if (rd_d) chk(rdata_o, q.pop_front());
  task ticks(input int n, input int x);
    int c;
    c = 0;
    repeat (n) begin
      @(negedge clk_i);
      c += int'(tick);
    end
    chk(16'(c), 16'(x));
  endtask
  function pllcg_word_t pick(input int k);
    return k == 0 ? en0 : (k == 1 ? en1 : en3);
  endfunction
  // Gate must keep its old value until two ticks after the write
  task en_delay(input int k, input pllcg_word_t idx);
    pllcg_word_t old, d;
    int t;
    old = pick(k);
    d = 16'($urandom);
    t = 0;
    wr(idx, d);
    repeat (12) begin
      @(negedge clk_i);
      chk(pick(k), t >= 2 ? d : old);
      t += int'(tick);
    end
    // Readback returns the written value, held from the write on, not the applied gate
    rd({idx, 2'h0}, d);
  endtask
  // Hang guard
  initial begin
    #60000;
    bad_count++;
    $display("[FAIL] %0t: run did not finish", $time);
    end_of_test();
  end
  initial begin
    void'($urandom(95));
    repeat (2) @(posedge clk_i);
    rstn_i <= 1'b1;
    @(negedge clk_i);
    chk(16'({lock, byp, mult}), 16'h0030);
    rd({STS, 2'h0}, 16'h0001);
    for (int i = 0; i < 7; i++) begin
      dv = 16'($urandom);
      sv[i] = dv;
      wr(regs[i], dv);
      rd({regs[i], 2'h0}, dv);
    end
    chk(hs, sv[0]);
    chk(ls, sv[1]);
    chk(16'(lpm), 16'(sv[2][1:0]));
    rd({16'h7012, 2'h0}, 16'h0);
    rd({STS, 2'h1}, 16'h0);
    rd({16'h7023, 2'h0}, 16'h0);
    $display("test registers done");
    // Watchdog off across ratio changes
    wr(`PLLCG_IDX_WD_CTRL, 16'h0000);
    // Multiplier and select against expected tick rate; select 3 is run
    // once bypassed and once with the loop locked
    for (int i = 0; i < 8; i++) begin
      // Multipliers go up to 7; rates above the oscillator are capped at one tick a cycle
      mm = i == 3 ? 0 : (i == 7 ? 1 : i + 1);
      wr(RAT, 16'(mm));
      rd({STS, 2'h0}, 16'h0);
      repeat (LCYC + 4) @(posedge clk_i);
      chk(16'(mult), 16'(mm));
      wr(STS, 16'((i % 4) << 1));
      dd = i % 4 < 2 ? 4 : (i % 4 == 2 || mm != 0 ? 2 : 1);
      e = 64 * (mm == 0 ? 1 : mm) / dd;
      repeat (4) @(posedge clk_i);
      ticks(64, e > 64 ? 64 : e);
      wr(STS, 16'h0);
    end
    rd({STS, 2'h0}, 16'h0001);
    wr(RAT, 16'h000b);
    rd({STS, 2'h0}, 16'h0001);
    chk(16'(mult), 16'(mm));
    $display("test rates done");
    wr(RAT, 16'h0);
    repeat (LCYC + 4) @(posedge clk_i);
    en_delay(0, `PLLCG_IDX_PCLK_EN0);
    en_delay(1, `PLLCG_IDX_PCLK_EN1);
    en_delay(3, `PLLCG_IDX_PCLK_EN3);
    $display("test enables done");
    repeat (3) @(posedge clk_i);
    if (q.size() != 0) bad_count++;
    end_of_test();
  end
endmodule
